/* File: rtl/hbc_pkg.sv */
// Constants for the host bridge control and status register slice.
// Assumes an 8-bit host register port decoded by the host interface logic.
package hbc_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] HBC_ADDR_READBACK_HIGH = 8'h57;
   localparam logic [7:0] HBC_ADDR_SPARE_CONTROL = 8'h5A;
   localparam logic [7:0] HBC_ADDR_BUFFER_STATUS = 8'h5C;
   localparam logic [7:0] HBC_ADDR_CPU_CONTROL = 8'h5D;
   localparam logic [7:0] HBC_ADDR_VENDOR_DOORBELL = 8'h60;
   localparam logic [7:0] HBC_ADDR_WAKE_EDGE = 8'h61;
   localparam logic [7:0] HBC_ADDR_TAKEOVER_LOW = 8'h62;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int HBC_BIT_STACKED_READY = 0;
   localparam int HBC_BIT_DISPLAY_READY = 1;
   localparam int HBC_BIT_SOFT_RESET = 0;
   localparam int HBC_BIT_RESERVED = 1;
   localparam int HBC_BIT_DOORBELL = 1;
   localparam int HBC_BIT_WAKE_RISE = 0;
   localparam int HBC_BIT_WAKE_FALL = 1;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] HBC_RST_SPARE = 8'h00;
   localparam logic [1:0] HBC_RST_CPU_CONTROL = 2'h1;
   localparam logic [1:0] HBC_RST_DOORBELL = 2'h0;
   localparam logic [1:0] HBC_RST_WAKE_EDGE = 2'h0;
   localparam logic [7:0] HBC_RST_TAKEOVER = 8'h00;

   // ------------------------------------------------------------------
   // Timing: cycles after reset release before the boot strap is taken.
   // ------------------------------------------------------------------
   localparam logic [1:0] HBC_STRAP_WAIT = 2'h3;

endpackage : hbc_pkg

/* File: rtl/hbc_wake_if.sv */
// Interface carrying chip-select edge events from the detector to the register slice.
// Assumes both ends run on the same free-running reference clock.
`timescale 1ns/10ps
interface hbc_wake_if;
   logic cs_rise;
   logic cs_fall;
   modport det (output cs_rise, output cs_fall);
   modport ctl (input cs_rise, input cs_fall);
endinterface : hbc_wake_if

/* File: rtl/hbc_wake_detect.sv */
// Chip-select pin synchroniser and edge detector.
// Assumes ref_clk_i runs while the core clocks are gated in suspend.
`timescale 1ns/10ps
module hbc_wake_detect
   import hbc_pkg::*;
(
   input wire logic ref_clk_i,   // Free-running reference clock.
   input wire logic sys_rst_i,   // Asynchronous reset, active high.
   input wire logic host_cs_n_i, // Host chip-select pin, asynchronous.
   hbc_wake_if.det wake          // Edge event pulses.
);
   logic cs_meta;
   logic cs_sync;
   logic cs_last;

   // Two stages before anything looks at the pin; the last stage feeds the edge logic.
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_last <= 1'b1;
      end else begin
         cs_meta <= host_cs_n_i;
         cs_sync <= cs_meta;
         cs_last <= cs_sync;
      end
   end

   assign wake.cs_rise = cs_sync & ~cs_last;
   assign wake.cs_fall = ~cs_sync & cs_last;

   AST_ONE_EDGE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !(wake.cs_rise && wake.cs_fall) and (wake.cs_rise |=> !wake.cs_rise))
      else $error("Edge pulses overlap or repeat.");

endmodule : hbc_wake_detect

/* File: rtl/hbc_control_status.sv */
// Host bridge control and status register slice.
// Assumes a single-cycle 8-bit register port from the host interface decoder.
//
// Operation
// - Read-back high byte is meaningless and reads zero with an 8-bit host bus.
// - Status bit 0 is read-only: stacked memory data ready for host reading.
// - Status bit 1 is read-only: display buffer data ready for host reading.
// - Writing one to CPU control bit 0 puts the embedded CPU in reset.
// - Soft reset bit resets to 0 for host boot, 1 for ROM boot.
// - In host boot the embedded CPU stays in reset until the host releases it.
// - Writing one to doorbell bit 1 interrupts the embedded CPU.
// - In suspend, only a chip-select change raises the resume interrupt.
// - Wake bit 0 set: chip-select rising edge raises a resume interrupt.
// - Wake bit 1 set: chip-select falling edge raises a resume interrupt.
// - Takeover select low is an 8-bit read/write register.
// - A takeover bit of one gives its pin to the host, zero to internal logic.
`timescale 1ns/10ps
module hbc_control_status
   import hbc_pkg::*;
(
   input wire logic ref_clk_i,                      // 50 MHz reference clock.
   input wire logic sys_rst_i,                      // Asynchronous reset, active high.
   input wire logic [7:0] reg_addr_i,               // Register offset.
   input wire logic [7:0] reg_wdata_i,              // Write data.
   input wire logic reg_wr_i,                       // Write strobe, one cycle.
   input wire logic reg_rd_i,                       // Read strobe, one cycle.
   output logic [7:0] reg_rdata_o,                  // Read data, registered.
   output logic reg_rvalid_o,                       // Read data valid pulse.
   input wire logic bus_8bit_i,                     // Host bus configured 8 bits wide.
   input wire logic [7:0] readback_check_high_i,    // Buffer write read-back high byte.
   input wire logic stacked_mem_read_ready_i,       // Stacked memory data ready.
   input wire logic display_buf_read_ready_i,       // Display buffer data ready.
   input wire logic boot_from_rom_i,                // Boot source strap pin.
   output logic embedded_cpu_reset_o,               // Embedded CPU reset, active high.
   output logic [7:0] spare_control_o,              // Spare control byte.
   output logic vendor_cmd_irq_o,                   // Doorbell interrupt pulse.
   input wire logic suspend_i,                      // Device is in suspend.
   input wire logic host_cs_n_i,                    // Host chip-select pin.
   output logic resume_irq_o,                       // Resume interrupt pulse.
   input wire logic [7:0] host_gpio_out_i,          // Host-owned pin values.
   input wire logic [7:0] host_gpio_oe_i,           // Host-owned pin enables.
   input wire logic [7:0] core_gpio_out_i,          // Internal pin values.
   input wire logic [7:0] core_gpio_oe_i,           // Internal pin enables.
   output logic [7:0] gpio_out_o,                   // Selected pin values.
   output logic [7:0] gpio_oe_o,                    // Selected pin enables.
   output logic [7:0] pin_takeover_select_low_o     // Takeover select register.
);

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction : hit

   logic wr_cpu;
   logic wr_bell;
   assign wr_cpu = reg_wr_i & hit(reg_addr_i, HBC_ADDR_CPU_CONTROL);
   assign wr_bell = reg_wr_i & hit(reg_addr_i, HBC_ADDR_VENDOR_DOORBELL);

   // ------------------------------------------------------------------
   // Boot strap capture
   // ------------------------------------------------------------------
   // The strap is synchronised and taken a few cycles after release, since an
   // asynchronous reset may only load constants.
   logic strap_meta;
   logic strap_sync;
   logic [1:0] strap_cnt;
   logic strap_done;
   logic host_boot;
   logic host_released;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
      end else begin
         strap_meta <= boot_from_rom_i;
         strap_sync <= strap_meta;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         strap_cnt <= 2'h0;
         strap_done <= 1'b0;
         host_boot <= 1'b0;
      end else if (!strap_done) begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == HBC_STRAP_WAIT) begin
            strap_done <= 1'b1;
            host_boot <= ~strap_sync;
         end
      end
   end

   // ------------------------------------------------------------------
   // CPU control
   // ------------------------------------------------------------------
   logic [1:0] cpu_control;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cpu_control <= HBC_RST_CPU_CONTROL;
      end else if (strap_done && wr_cpu) begin
         cpu_control <= reg_wdata_i[1:0];
      end else if (strap_cnt == HBC_STRAP_WAIT && !strap_done) begin
         cpu_control[HBC_BIT_SOFT_RESET] <= strap_sync;
      end
   end

   // A host-boot part must not run its CPU before code is loaded, even though
   // the soft reset bit itself reads zero; the host's zero write releases it.
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         host_released <= 1'b0;
      end else if (strap_done && wr_cpu && !reg_wdata_i[HBC_BIT_SOFT_RESET]) begin
         host_released <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         embedded_cpu_reset_o <= 1'b1;
      end else begin
         embedded_cpu_reset_o <= !strap_done || cpu_control[HBC_BIT_SOFT_RESET]
                                 || (host_boot && !host_released);
      end
   end

   // ------------------------------------------------------------------
   // Doorbell, spare, wake enables, takeover
   // ------------------------------------------------------------------
   logic [1:0] doorbell;
   logic [1:0] wake_edge_enable;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         doorbell <= HBC_RST_DOORBELL;
         vendor_cmd_irq_o <= 1'b0;
      end else begin
         if (wr_bell) begin
            doorbell <= reg_wdata_i[1:0];
         end
         vendor_cmd_irq_o <= wr_bell & reg_wdata_i[HBC_BIT_DOORBELL];
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         spare_control_o <= HBC_RST_SPARE;
         wake_edge_enable <= HBC_RST_WAKE_EDGE;
         pin_takeover_select_low_o <= HBC_RST_TAKEOVER;
      end else if (reg_wr_i) begin
         if (hit(reg_addr_i, HBC_ADDR_SPARE_CONTROL)) begin
            spare_control_o <= reg_wdata_i;
         end
         if (hit(reg_addr_i, HBC_ADDR_WAKE_EDGE)) begin
            wake_edge_enable <= reg_wdata_i[1:0];
         end
         if (hit(reg_addr_i, HBC_ADDR_TAKEOVER_LOW)) begin
            pin_takeover_select_low_o <= reg_wdata_i;
         end
      end
   end

   assign gpio_out_o = (pin_takeover_select_low_o & host_gpio_out_i)
                       | (~pin_takeover_select_low_o & core_gpio_out_i);
   assign gpio_oe_o = (pin_takeover_select_low_o & host_gpio_oe_i)
                      | (~pin_takeover_select_low_o & core_gpio_oe_i);

   // ------------------------------------------------------------------
   // Resume interrupt
   // ------------------------------------------------------------------
   hbc_wake_if wake ();

   hbc_wake_detect u_wake (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .host_cs_n_i(host_cs_n_i),
      .wake(wake.det)
   );

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         resume_irq_o <= 1'b0;
      end else begin
         resume_irq_o <= suspend_i
            && ((wake.cs_rise && wake_edge_enable[HBC_BIT_WAKE_RISE])
            || (wake.cs_fall && wake_edge_enable[HBC_BIT_WAKE_FALL]));
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr_i)
         HBC_ADDR_READBACK_HIGH: next_rdata = bus_8bit_i ? 8'h00 : readback_check_high_i;
         HBC_ADDR_SPARE_CONTROL: next_rdata = spare_control_o;
         HBC_ADDR_BUFFER_STATUS: next_rdata = {6'h00, display_buf_read_ready_i,
                                               stacked_mem_read_ready_i};
         HBC_ADDR_CPU_CONTROL: next_rdata = {6'h00, cpu_control};
         HBC_ADDR_VENDOR_DOORBELL: next_rdata = {6'h00, doorbell};
         HBC_ADDR_WAKE_EDGE: next_rdata = {6'h00, wake_edge_enable};
         HBC_ADDR_TAKEOVER_LOW: next_rdata = pin_takeover_select_low_o;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
         end
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence seq_read_at(logic [7:0] a);
      reg_rd_i && reg_addr_i == a;
   endsequence

   sequence seq_write_at(logic [7:0] a);
      reg_wr_i && reg_addr_i == a;
   endsequence

   AST_HIGH_BYTE_8BIT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      seq_read_at(HBC_ADDR_READBACK_HIGH) and bus_8bit_i |=> reg_rvalid_o && reg_rdata_o == 8'h00)
      else $error("Read-back high byte not zero on 8-bit bus.");

   AST_STACKED_READY: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      seq_read_at(HBC_ADDR_BUFFER_STATUS)
      |=> reg_rdata_o[HBC_BIT_STACKED_READY] == $past(stacked_mem_read_ready_i))
      else $error("Stacked memory ready flag read wrong.");

   AST_DISPLAY_READY: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      seq_read_at(HBC_ADDR_BUFFER_STATUS)
      |=> reg_rdata_o[HBC_BIT_DISPLAY_READY] == $past(display_buf_read_ready_i))
      else $error("Display ready flag read wrong.");

   AST_SOFT_RESET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      strap_done ##0 seq_write_at(HBC_ADDR_CPU_CONTROL) ##0 reg_wdata_i[HBC_BIT_SOFT_RESET]
      |=> ##1 embedded_cpu_reset_o)
      else $error("Soft reset write did not reset the CPU.");

   AST_STRAP_DEFAULT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $rose(strap_done) |-> cpu_control[HBC_BIT_SOFT_RESET] == !host_boot)
      else $error("Soft reset bit default disagrees with boot source.");

   AST_HOST_BOOT_HOLD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      host_boot && !host_released |=> embedded_cpu_reset_o)
      else $error("CPU left reset before host release.");

   AST_DOORBELL: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      seq_write_at(HBC_ADDR_VENDOR_DOORBELL) ##0 reg_wdata_i[HBC_BIT_DOORBELL]
      |=> vendor_cmd_irq_o ##1 !vendor_cmd_irq_o || $past(wr_bell))
      else $error("Doorbell interrupt not a single pulse.");

   AST_WAKE_ONLY_SUSPEND: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      resume_irq_o |-> $past(suspend_i) && ($past(wake.cs_rise) || $past(wake.cs_fall)))
      else $error("Resume interrupt outside suspend or without an edge.");

   AST_WAKE_RISE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      suspend_i && wake.cs_rise && wake_edge_enable[HBC_BIT_WAKE_RISE] |=> resume_irq_o)
      else $error("Rising chip-select edge did not wake.");

   AST_WAKE_FALL: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      suspend_i && wake.cs_fall && wake_edge_enable[HBC_BIT_WAKE_FALL] |=> resume_irq_o)
      else $error("Falling chip-select edge did not wake.");

   AST_TAKEOVER_WRITE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      seq_write_at(HBC_ADDR_TAKEOVER_LOW) |=> pin_takeover_select_low_o == $past(reg_wdata_i))
      else $error("Takeover select write lost.");

endmodule : hbc_control_status

/* File: testbench/hbc_host_model.sv */
// Host processor model: drives the register port and the chip-select pin.
// Assumes one shared reference clock; all changes land 1 ns after its rising edge.
`timescale 1ns/10ps
module hbc_host_model
   import hbc_pkg::*;
(
   input wire logic ref_clk_i,         // Reference clock.
   input wire logic [7:0] reg_rdata_i, // Read data.
   input wire logic reg_rvalid_i,      // Read data valid.
   output logic [7:0] reg_addr_o,      // Register offset.
   output logic [7:0] reg_wdata_o,     // Write data.
   output logic reg_wr_o,              // Write strobe.
   output logic reg_rd_o,              // Read strobe.
   output logic host_cs_n_o            // Chip-select pin, idle high.
);
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      host_cs_n_o = 1'b1;
   end

   // Released lines show the inverse value so a stale sample cannot match.
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == HBC_ADDR_CPU_CONTROL) begin
         v[HBC_BIT_RESERVED] = 1'b0;
      end
      @(posedge ref_clk_i);
      #1;
      reg_addr_o = a;
      reg_wdata_o = v;
      reg_wr_o = 1'b1;
      @(posedge ref_clk_i);
      #1;
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~v;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      int n;
      @(posedge ref_clk_i);
      #1;
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(posedge ref_clk_i);
      #1;
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      n = 0;
      while (reg_rvalid_i !== 1'b1 && n < 4) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      ok = (reg_rvalid_i === 1'b1);
      d = reg_rdata_i;
   endtask : read_reg

   // The data port may only be read once the matching ready flag is seen.
   task automatic wait_ready(input int b, output logic ok);
      logic [7:0] d;
      logic v;
      ok = 1'b0;
      for (int i = 0; i < 20 && !ok; i++) begin
         read_reg(HBC_ADDR_BUFFER_STATUS, d, v);
         ok = v && (d[b] === 1'b1);
      end
   endtask : wait_ready

   task automatic cs_cycle();
      @(posedge ref_clk_i);
      #1;
      host_cs_n_o = 1'b0;
      repeat (6) @(posedge ref_clk_i);
      #1;
      host_cs_n_o = 1'b1;
      repeat (8) @(posedge ref_clk_i);
   endtask : cs_cycle
endmodule : hbc_host_model

/* File: testbench/test_hbc_control_status.sv */
// Self-checking bench for the host bridge register slice.
// Assumes the host model above drives the register port and chip-select.
`timescale 1ns/10ps
module test_hbc_control_status
   import hbc_pkg::*;
;
   logic ref_clk_i, sys_rst_i, bus_8bit_i, stk_i, disp_i, rom_i, suspend_i, cs_n;
   logic [7:0] addr, wdata, rdata, rbh, spare, ho, hoe, co, coe, go, goe, sel;
   logic wr, rd, rvalid, cpu_rst, vc_irq, res_irq, ok;
   int fails = 0;
   int checked = 0;
   int n_vc = 0;
   int n_res = 0;

   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   hbc_host_model host_inst (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata),
      .reg_rvalid_i(rvalid), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
      .reg_rd_o(rd), .host_cs_n_o(cs_n));

   hbc_control_status hbc_control_status_inst (.ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .bus_8bit_i(bus_8bit_i),
      .readback_check_high_i(rbh), .stacked_mem_read_ready_i(stk_i),
      .display_buf_read_ready_i(disp_i), .boot_from_rom_i(rom_i),
      .embedded_cpu_reset_o(cpu_rst), .spare_control_o(spare), .vendor_cmd_irq_o(vc_irq),
      .suspend_i(suspend_i), .host_cs_n_i(cs_n), .resume_irq_o(res_irq),
      .host_gpio_out_i(ho), .host_gpio_oe_i(hoe), .core_gpio_out_i(co),
      .core_gpio_oe_i(coe), .gpio_out_o(go), .gpio_oe_o(goe),
      .pin_takeover_select_low_o(sel));

   always @(posedge ref_clk_i) begin
      if (vc_irq === 1'b1) n_vc <= n_vc + 1;
      if (res_irq === 1'b1) n_res <= n_res + 1;
   end

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      host_inst.read_reg(a, d, v);
      check("rvalid", {7'h00, v}, 8'h01);
      check($sformatf("reg %h", a), d, exp);
   endtask : rchk

   task automatic do_reset(input logic rom);
      @(posedge ref_clk_i);
      #1;
      rom_i = rom;
      sys_rst_i = 1'b1;
      repeat (4) @(posedge ref_clk_i);
      #1;
      sys_rst_i = 1'b0;
      repeat (8) @(posedge ref_clk_i);
   endtask : do_reset

   task automatic cpu_chk(input logic exp);
      repeat (3) @(posedge ref_clk_i);
      #1;
      check("cpu_reset", {7'h00, cpu_rst}, {7'h00, exp});
   endtask : cpu_chk

   task automatic report_and_stop();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #(20 * 20000);
      fails++;
      report_and_stop();
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      {sys_rst_i, bus_8bit_i, stk_i, disp_i, rom_i, suspend_i} = 6'h21;
      {ho, hoe, co, coe, rbh} = {8'h3C, 8'hF0, 8'hC3, 8'h0F, 8'hA5};
      do_reset(1'b0);
      rchk(HBC_ADDR_CPU_CONTROL, 8'h00);
      cpu_chk(1'b1);
      host_inst.write_reg(HBC_ADDR_CPU_CONTROL, 8'h00);
      cpu_chk(1'b0);
      host_inst.write_reg(HBC_ADDR_CPU_CONTROL, 8'h03);
      cpu_chk(1'b1);
      rchk(HBC_ADDR_CPU_CONTROL, 8'h01);
      for (int i = 0; i < 4; i++) begin
         {disp_i, stk_i} = 2'(i);
         rchk(HBC_ADDR_BUFFER_STATUS, 8'(i));
      end
      host_inst.write_reg(HBC_ADDR_BUFFER_STATUS, 8'h00);
      rchk(HBC_ADDR_BUFFER_STATUS, 8'h03);
      host_inst.wait_ready(HBC_BIT_DISPLAY_READY, ok);
      check("ready_poll", {7'h00, ok}, 8'h01);
      bus_8bit_i = 1'b0;
      rchk(HBC_ADDR_READBACK_HIGH, 8'hA5);
      bus_8bit_i = 1'b1;
      rchk(HBC_ADDR_READBACK_HIGH, 8'h00);
      rchk(8'h58, 8'h00);
      n_vc = 0;
      host_inst.write_reg(HBC_ADDR_VENDOR_DOORBELL, 8'h02);
      host_inst.write_reg(HBC_ADDR_VENDOR_DOORBELL, 8'h01);
      repeat (3) @(posedge ref_clk_i);
      check("doorbell", 8'(n_vc), 8'h01);
      rchk(HBC_ADDR_VENDOR_DOORBELL, 8'h01);
      for (int e = 0; e < 5; e++) begin
         // The wake enable is set while suspend is already high.
         // The last pass enables both edges, then drops suspend before the cycle, so only suspend gates it.
         host_inst.write_reg(HBC_ADDR_WAKE_EDGE, 8'((e < 4) ? e : 3));
         suspend_i = (e < 4);
         n_res = 0;
         host_inst.cs_cycle();
         check("resume", 8'(n_res), (e < 4) ? 8'(e % 2) + 8'(e / 2) : 8'h00);
      end
      check("gpio_rst", go, co);
      host_inst.write_reg(HBC_ADDR_TAKEOVER_LOW, 8'hA5);
      host_inst.write_reg(HBC_ADDR_SPARE_CONTROL, 8'h5A);
      rchk(HBC_ADDR_TAKEOVER_LOW, 8'hA5);
      check("sel", sel, 8'hA5);
      check("gpio_out", go, (ho & 8'hA5) | (co & 8'h5A));
      check("gpio_oe", goe, (hoe & 8'hA5) | (coe & 8'h5A));
      check("spare", spare, 8'h5A);
      do_reset(1'b1);
      rchk(HBC_ADDR_CPU_CONTROL, 8'h01);
      rchk(HBC_ADDR_SPARE_CONTROL, HBC_RST_SPARE);
      rchk(HBC_ADDR_TAKEOVER_LOW, HBC_RST_TAKEOVER);
      host_inst.write_reg(HBC_ADDR_CPU_CONTROL, 8'h00);
      cpu_chk(1'b0);
      report_and_stop();
   end
endmodule : test_hbc_control_status
